// *** rtl/pmc_map.svh ***
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// register byte offsets on the APB
`define OSC_CTRL_OFFS 12'h000
`define T1_CTRL_OFFS 12'h004
`define MODE_STAT_OFFS 12'h008

// field positions
`define IDLE_SEL_BIT 7
`define PRI_FLAG_BIT 3
`define SCS_MSB 1
`define SCS_LSB 0
`define SEC_FLAG_BIT 6
`define SEC_EN_BIT 3
`define STAT_STATE_MSB 7
`define STAT_SRC_LSB 8
`define STAT_SRC_MSB 9

// reset values
`define SCS_RST 2'h2
`define IDLE_SEL_RST 1'h0
`define SEC_EN_RST 1'h0

// switch gap: outgoing cycles plus worst-case incoming cycles
`define SW_OLD_CYCLES 2
`define SW_NEW_CYCLES 4
`define SW_TOTAL_CYCLES (`SW_OLD_CYCLES + `SW_NEW_CYCLES)

// cpu_ready_delay, rounded up to whole clock cycles
`define CLK_PERIOD_NS 4
`define CPU_READY_DELAY_NS 200
`define CPU_READY_DELAY_CYC ((`CPU_READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/pmc_pkg.sv ***
package pmc_pkg;

  // clock_source_select codes; 00 falls to the internal source
  typedef enum logic [1:0] {
    SRC_SEC = 2'h1,
    SRC_PRI = 2'h2,
    SRC_RC = 2'h3
  } src_t;

  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_RUN = 8'h02,
    ST_WAIT = 8'h04,
    ST_SWITCH = 8'h08,
    ST_IDLE = 8'h10,
    ST_SLEEP = 8'h20,
    ST_WAKE = 8'h40,
    ST_CPU_DLY = 8'h80
  } state_t;

  typedef struct packed {
    state_t state;
    src_t cur_src;
    src_t tgt_src;
    logic after_dly;
    logic idle_sel;
    logic [1:0] scs;
    logic sec_osc_enable;
    logic pri_flag;
    logic sec_flag;
    logic pri_osc;
    logic sec_osc;
    logic rc_osc;
    logic cpu_en;
    logic periph_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmc_state_t;

endpackage

// *** rtl/pmc_sync2.sv ***
`timescale 1ns/100ps
module pmc_sync2 #(
  parameter int W = 3
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r_r;
  sync_t r_nxt;

  // s1 feeds s2 only
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;

endmodule

// *** rtl/pmc_timer.sv ***
`timescale 1ns/100ps
module pmc_timer #(
  parameter int W = 8
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic load, // load pulse
  input wire logic [W-1:0] load_val, // cycles minus one
  output logic expired // count has reached zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t r_r;
  tmr_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (load) begin
      r_nxt.cnt = load_val;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign expired = (r_r.cnt == '0);

endmodule

// *** rtl/power_mode_clock_switch.sv ***
// Notes on behaviour
// - a source switch gaps clocks two outgoing plus four incoming cycles
// - primary flag bit 3 on primary, secondary flag bit 6 on Timer1 source
// - a sleep pulse in Run samples idle_select then to pick Idle or Sleep
// - every Run mode clocks both CPU and peripherals
// - after reset start in primary_run with primary flag, unless two-speed
// - select 01 moves to Timer1 source, stops primary, swaps flags
// - select 01 with secondary_osc_enable clear never enters secondary_run
// - Timer1 enabled but not running: clocks held until it starts
// - secondary to primary keeps Timer1 clock until primary ready, then swaps
// - select 11 moves to internal_rc_clock, stops primary, clears flag
// - internal to primary keeps RC clock until primary ready, then flag set
// - internal RC runs whenever watchdog or fail-safe monitor enabled
// - sleep with idle_select clear stops oscillator, clears all flags
// - Sleep needs no switch; RC kept for watchdog, Timer1 kept if enabled
// - wake from Sleep withholds clocks until source ready, or clocks peripherals from RC
// - only software writes change idle_select and clock_source_select
// - Idle gates CPU clock, peripherals keep selected source, flags unchanged
// - Idle exits on interrupt, watchdog or reset, after cpu_ready_delay
// - watchdog time-out in Idle or Sleep wakes into selected Run mode
// - primary_idle keeps primary running and its flag set
// - wake from primary_idle clocks CPU from primary after delay
// - idle_select at bit 7, clock_source_select at bits 1:0
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "pmc_map.svh"
module power_mode_clock_switch
  import pmc_pkg::*;
#(
  parameter int TW = 8
) (
  input wire logic CLK, // core clock, 250 MHz
  input wire logic RST_N, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic SLEEP_EXEC, // sleep instruction pulse
  input wire logic WAKE_IRQ, // enabled interrupt pending
  input wire logic WDT_TIMEOUT, // watchdog time-out
  input wire logic WDT_EN, // watchdog enabled
  input wire logic FSCM_EN, // fail-safe clock monitor enabled
  input wire logic TWO_SPEED_EN, // two-speed start-up enabled
  input wire logic PRI_OSC_READY, // primary oscillator ready, async pin
  input wire logic SEC_OSC_READY, // Timer1 oscillator running, async pin
  input wire logic RC_OSC_READY, // internal RC running, async pin
  output logic PRI_OSC_EN, // primary oscillator enable
  output logic SEC_OSC_EN, // Timer1 oscillator enable
  output logic RC_OSC_EN, // internal RC enable
  output logic [1:0] CLK_SEL, // device clock mux select
  output logic CPU_CLK_EN, // cpu clock gate
  output logic PERIPH_CLK_EN // peripheral clock gate
);

  localparam logic [TW-1:0] SW_LOAD = TW'(`SW_TOTAL_CYCLES - 1);
  localparam logic [TW-1:0] DLY_LOAD = TW'(`CPU_READY_DELAY_CYC - 1);

  localparam pmc_state_t RST_VAL = '{
    state: ST_BOOT,
    cur_src: SRC_PRI,
    tgt_src: SRC_PRI,
    after_dly: 1'b0,
    idle_sel: `IDLE_SEL_RST,
    scs: `SCS_RST,
    sec_osc_enable: `SEC_EN_RST,
    pri_flag: 1'b1,
    sec_flag: 1'b0,
    pri_osc: 1'b1,
    sec_osc: 1'b0,
    rc_osc: 1'b0,
    cpu_en: 1'b0,
    periph_en: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  pmc_state_t r_r;
  pmc_state_t r_nxt;

  logic [2:0] rdy_sync;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_exp;
  logic apb_acc;
  logic apb_wr;
  logic [31:0] rd_word;
  logic rd_err;
  src_t want_src;
  logic want_blocked;
  logic wake;
  logic fast_wake;
  logic held_state;

  pmc_sync2 #(.W(3)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({RC_OSC_READY, SEC_OSC_READY, PRI_OSC_READY}),
    .q(rdy_sync)
  );

  pmc_timer #(.W(TW)) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  function automatic src_t src_of(input logic [1:0] code);
    src_t s;
    s = SRC_RC;
    if (code == 2'h1) begin
      s = SRC_SEC;
    end else if (code == 2'h2) begin
      s = SRC_PRI;
    end
    return s;
  endfunction

  function automatic logic ready_of(input src_t s, input logic [2:0] rdy);
    logic v;
    v = rdy[2];
    if (s == SRC_PRI) begin
      v = rdy[0];
    end else if (s == SRC_SEC) begin
      v = rdy[1];
    end
    return v;
  endfunction

  assign apb_acc = PSEL & PENABLE;
  assign apb_wr = apb_acc & r_r.pready & PWRITE;
  assign wake = WAKE_IRQ | WDT_TIMEOUT;
  assign fast_wake = TWO_SPEED_EN | FSCM_EN;
  assign want_src = src_of(r_r.scs);
  assign want_blocked = (want_src == SRC_SEC) && !r_r.sec_osc_enable;

  // register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (PADDR == `OSC_CTRL_OFFS) begin
      rd_word[`IDLE_SEL_BIT] = r_r.idle_sel;
      rd_word[`PRI_FLAG_BIT] = r_r.pri_flag;
      rd_word[`SCS_MSB:`SCS_LSB] = r_r.scs;
    end else if (PADDR == `T1_CTRL_OFFS) begin
      rd_word[`SEC_FLAG_BIT] = r_r.sec_flag;
      rd_word[`SEC_EN_BIT] = r_r.sec_osc_enable;
    end else if (PADDR == `MODE_STAT_OFFS) begin
      rd_word[`STAT_STATE_MSB:0] = r_r.state;
      rd_word[`STAT_SRC_MSB:`STAT_SRC_LSB] = r_r.cur_src;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    r_nxt = r_r;
    tmr_load = 1'b0;
    tmr_val = SW_LOAD;
    // one wait state: pready rises in the second access cycle
    r_nxt.pready = apb_acc & ~r_r.pready;
    if (apb_acc && !r_r.pready) begin
      r_nxt.prdata = PWRITE ? 32'h0000_0000 : rd_word;
      r_nxt.pslverr = rd_err;
    end
    // only these writes touch the mode bits
    if (apb_wr && PADDR == `OSC_CTRL_OFFS) begin
      r_nxt.idle_sel = PWDATA[`IDLE_SEL_BIT];
      r_nxt.scs = PWDATA[`SCS_MSB:`SCS_LSB];
    end else if (apb_wr && PADDR == `T1_CTRL_OFFS) begin
      r_nxt.sec_osc_enable = PWDATA[`SEC_EN_BIT];
    end

    case (r_r.state)
      ST_BOOT: begin
        if (TWO_SPEED_EN) begin
          r_nxt.cur_src = SRC_RC;
          r_nxt.tgt_src = SRC_PRI;
          r_nxt.state = ST_WAIT;
        end else begin
          r_nxt.cur_src = SRC_PRI;
          r_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (SLEEP_EXEC) begin
          if (!r_r.idle_sel) begin
            r_nxt.state = ST_SLEEP;
          end else if (!want_blocked) begin
            r_nxt.state = ST_IDLE;
          end
        end else if (!want_blocked && want_src != r_r.cur_src) begin
          r_nxt.tgt_src = want_src;
          r_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // old source stays selected until the new one is up; clocks are gated while a Timer1 target is not yet running
        if (ready_of(r_r.tgt_src, rdy_sync)) begin
          r_nxt.state = ST_SWITCH;
          tmr_load = 1'b1;
        end
      end
      ST_SWITCH: begin
        if (tmr_exp) begin
          r_nxt.cur_src = r_r.tgt_src;
          r_nxt.after_dly = 1'b0;
          if (r_r.after_dly) begin
            r_nxt.state = ST_CPU_DLY;
            tmr_load = 1'b1;
            tmr_val = DLY_LOAD;
          end else begin
            r_nxt.state = ST_RUN;
          end
        end
      end
      ST_IDLE: begin
        if (wake) begin
          r_nxt.state = ST_CPU_DLY;
          tmr_load = 1'b1;
          tmr_val = DLY_LOAD;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          r_nxt.tgt_src = want_blocked ? SRC_RC : want_src;
          r_nxt.state = ST_WAKE;
          if (fast_wake) begin
            r_nxt.cur_src = SRC_RC;
          end
        end
      end
      ST_WAKE: begin
        if (ready_of(r_r.tgt_src, rdy_sync)) begin
          tmr_load = 1'b1;
          if (fast_wake && r_r.cur_src != r_r.tgt_src) begin
            r_nxt.after_dly = 1'b1;
            r_nxt.state = ST_SWITCH;
          end else begin
            r_nxt.cur_src = r_r.tgt_src;
            r_nxt.state = ST_CPU_DLY;
            tmr_val = DLY_LOAD;
          end
        end
      end
      ST_CPU_DLY: begin
        if (tmr_exp) begin
          r_nxt.state = ST_RUN;
        end
      end
      default: begin
        r_nxt.state = ST_BOOT;
      end
    endcase

    // outputs follow the next state so they line up with it
    held_state = (r_nxt.state == ST_WAIT) || (r_nxt.state == ST_SWITCH)
                 || (r_nxt.state == ST_WAKE);
    r_nxt.cpu_en = (r_nxt.state == ST_RUN)
                   || (r_nxt.state == ST_WAIT
                       && (r_nxt.tgt_src != SRC_SEC || rdy_sync[1]));
    r_nxt.periph_en = r_nxt.cpu_en || (r_nxt.state == ST_IDLE)
                      || (r_nxt.state == ST_CPU_DLY)
                      || (r_nxt.state == ST_WAKE && fast_wake);
    // flags track the source in use; cleared while asleep or waking
    r_nxt.pri_flag = (r_nxt.cur_src == SRC_PRI) && (r_nxt.state != ST_SLEEP)
                     && (r_nxt.state != ST_WAKE);
    r_nxt.sec_flag = (r_nxt.cur_src == SRC_SEC) && (r_nxt.state != ST_SLEEP)
                     && (r_nxt.state != ST_WAKE);
    r_nxt.pri_osc = (r_nxt.state != ST_SLEEP) && ((r_nxt.cur_src == SRC_PRI)
                    || (held_state && r_nxt.tgt_src == SRC_PRI));
    // Timer1 stays under software control, also across switches and Sleep
    r_nxt.sec_osc = r_nxt.sec_osc_enable;
    r_nxt.rc_osc = WDT_EN || FSCM_EN
                   || (r_nxt.state != ST_SLEEP && r_nxt.cur_src == SRC_RC)
                   || (held_state && r_nxt.tgt_src == SRC_RC)
                   || (r_nxt.state == ST_WAKE && fast_wake);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_r <= RST_VAL;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign PRDATA = r_r.prdata;
  assign PREADY = r_r.pready;
  assign PSLVERR = r_r.pslverr;
  assign PRI_OSC_EN = r_r.pri_osc;
  assign SEC_OSC_EN = r_r.sec_osc;
  assign RC_OSC_EN = r_r.rc_osc;
  assign CLK_SEL = r_r.cur_src;
  assign CPU_CLK_EN = r_r.cpu_en;
  assign PERIPH_CLK_EN = r_r.periph_en;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_enter_switch;
    r_r.state != ST_SWITCH && r_nxt.state == ST_SWITCH;
  endsequence

  sequence s_gap;
    (r_r.state == ST_SWITCH && !PERIPH_CLK_EN)[*6] ##1 r_r.state != ST_SWITCH;
  endsequence

  property p_switch_gap;
    s_enter_switch |=> s_gap;
  endproperty
  a_switch_gap: assert property (p_switch_gap)
    else $error("switch gap not six cycles");
  property p_flags;
    (r_r.pri_flag |-> CLK_SEL == SRC_PRI) and (r_r.sec_flag |-> CLK_SEL == SRC_SEC)
    and !(r_r.pri_flag && r_r.sec_flag);
  endproperty
  a_flags: assert property (p_flags)
    else $error("clock status flags disagree with source");
  property p_sleep_pick;
    (r_r.state == ST_RUN && SLEEP_EXEC && !r_r.idle_sel) |=> r_r.state == ST_SLEEP;
  endproperty
  a_sleep_pick: assert property (p_sleep_pick)
    else $error("sleep with idle_select clear did not sleep");
  property p_sleep_flags;
    (r_r.state == ST_SLEEP) |-> !PRI_OSC_EN && !r_r.pri_flag && !r_r.sec_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep left a flag or primary set");
  property p_scs_sw_only;
    !(apb_wr && PADDR == `OSC_CTRL_OFFS) |=> $stable(r_r.scs) && $stable(r_r.idle_sel);
  endproperty
  a_scs_sw_only: assert property (p_scs_sw_only)
    else $error("mode bits changed without a write");
  property p_no_sec_blocked;
    (r_r.state == ST_RUN && want_blocked && r_r.cur_src != SRC_SEC)
      |=> r_r.cur_src != SRC_SEC;
  endproperty
  a_no_sec_blocked: assert property (p_no_sec_blocked)
    else $error("entered secondary without oscillator enable");
  property p_idle_exit;
    (r_r.state == ST_IDLE && wake) |=> r_r.state == ST_CPU_DLY && !CPU_CLK_EN
      && PERIPH_CLK_EN && $stable(CLK_SEL);
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle exit not into cpu delay");
  property p_dly_end;
    (r_r.state == ST_CPU_DLY && tmr_exp) |=> r_r.state == ST_RUN && CPU_CLK_EN;
  endproperty
  a_dly_end: assert property (p_dly_end)
    else $error("cpu delay did not end in run");
  property p_rc_keep;
    (WDT_EN || FSCM_EN) |=> RC_OSC_EN;
  endproperty
  a_rc_keep: assert property (p_rc_keep)
    else $error("internal RC stopped while needed");
  property p_idle_gate;
    (r_r.state == ST_IDLE) |-> !CPU_CLK_EN && PERIPH_CLK_EN && $stable(r_r.pri_flag);
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("idle clock gating wrong");

endmodule

// *** verif/pmc_osc_model.sv ***
`timescale 1ns/100ps
module pmc_osc_model #(
  parameter int START = 20
) (
  input wire logic clk, // core clock
  input wire logic en, // oscillator enable
  output logic ready // running level
);
  int cnt = 0;
  initial ready = 1'b0;
  // ready drops at once on disable, so a stale level never hides a restart
  always @(posedge clk) begin
    if (en !== 1'b1) begin
      cnt <= 0;
      ready <= 1'b0;
    end else if (cnt < START) begin
      cnt <= cnt + 1;
    end else begin
      ready <= 1'b1;
    end
  end
endmodule

// *** verif/power_mode_clock_switch_tb_top.sv ***
`timescale 1ns/100ps
`include "pmc_map.svh"
module power_mode_clock_switch_tb_top;
  typedef struct {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } row_t;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
  logic PREADY, PSLVERR, e, SLEEP_EXEC = 1'b0, WAKE_IRQ = 1'b0, WDT_TIMEOUT = 1'b0;
  logic WDT_EN = 1'b0, FSCM_EN = 1'b0, TWO_SPEED_EN = 1'b0, CPU_CLK_EN, PERIPH_CLK_EN;
  logic [2:0] osc_en, osc_rdy;
  logic [1:0] CLK_SEL;
  int errors = 0, samples_checked = 0, n;
  row_t rows[7];
  always #2 CLK = ~CLK;
  power_mode_clock_switch power_mode_clock_switch_inst (.CLK(CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_EXEC(SLEEP_EXEC),
    .WAKE_IRQ(WAKE_IRQ), .WDT_TIMEOUT(WDT_TIMEOUT), .WDT_EN(WDT_EN), .FSCM_EN(FSCM_EN),
    .TWO_SPEED_EN(TWO_SPEED_EN), .PRI_OSC_READY(osc_rdy[2]), .SEC_OSC_READY(osc_rdy[1]),
    .RC_OSC_READY(osc_rdy[0]), .PRI_OSC_EN(osc_en[2]), .SEC_OSC_EN(osc_en[1]),
    .RC_OSC_EN(osc_en[0]), .CLK_SEL(CLK_SEL), .CPU_CLK_EN(CPU_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN));
  pmc_osc_model pmc_osc_model_inst[2:0] (.clk(CLK), .en(osc_en), .ready(osc_rdy));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    PSEL <= 1'b1;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 20) begin
      errors++;
      close_out();
    end
    @(posedge CLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, r, x);
  endtask
  // sampled at the edge, so k counts edges up to and including the one showing the awaited value
  task automatic waitv(input bit cpu, input logic [1:0] v, output int k);
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while ((cpu ? {1'b0, CPU_CLK_EN} : CLK_SEL) !== v && k < 500);
    if (k >= 500) begin
      errors++;
      close_out();
    end
  endtask
  task automatic sleep_cmd();
    SLEEP_EXEC <= 1'b1;
    @(posedge CLK);
    SLEEP_EXEC <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask
  initial begin
    rows = '{
      '{`OSC_CTRL_OFFS, 1'b0, 32'h0000_0000, 32'h0000_000A, 1'b0},
      '{`T1_CTRL_OFFS, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{`MODE_STAT_OFFS, 1'b0, 32'h0000_0000, 32'h0000_0202, 1'b0},
      '{`OSC_CTRL_OFFS, 1'b1, 32'h0000_0006, 32'h0000_0000, 1'b0},
      '{`OSC_CTRL_OFFS, 1'b0, 32'h0000_0000, 32'h0000_000A, 1'b0},
      '{12'h00C, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
      '{12'h00C, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1}};
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    waitv(1'b1, 2'h1, n);
    chk("run_src", {CLK_SEL, PERIPH_CLK_EN}, 3'b101);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("rdata", r, rows[i].x);
      chk("pslverr", e, rows[i].e);
    end
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0001);
    repeat (40) @(posedge CLK);
    chk("sec_refused", CLK_SEL, 2'h2);
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0002);
    apb(`T1_CTRL_OFFS, 1'b1, 32'h0000_0008);
    repeat (40) @(posedge CLK);
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0001);
    waitv(1'b1, 2'h0, n);
    waitv(1'b1, 2'h1, n);
    chk("switch_gap", n, `SW_TOTAL_CYCLES);
    chk("secondary_run", {CLK_SEL, osc_en[2], PERIPH_CLK_EN}, 4'b0101);
    rd(`T1_CTRL_OFFS, 32'h0000_0048, "t1_flags");
    rd(`OSC_CTRL_OFFS, 32'h0000_0001, "osc_sec");
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0002);
    repeat (3) @(posedge CLK);
    chk("hold_sec", {CLK_SEL, CPU_CLK_EN}, 3'b011);
    waitv(1'b0, 2'h2, n);
    waitv(1'b1, 2'h1, n);
    rd(`T1_CTRL_OFFS, 32'h0000_0008, "t1_back");
    rd(`OSC_CTRL_OFFS, 32'h0000_000A, "osc_back");
    chk("sec_kept", osc_en[1], 1'b1);
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0082);
    sleep_cmd();
    chk("idle", {CPU_CLK_EN, PERIPH_CLK_EN, osc_en[2], CLK_SEL}, 5'b01110);
    WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    WAKE_IRQ <= 1'b0;
    waitv(1'b1, 2'h1, n);
    chk("idle_delay", n >= `CPU_READY_DELAY_CYC && n <= `CPU_READY_DELAY_CYC + 4, 1);
    rd(`OSC_CTRL_OFFS, 32'h0000_008A, "idle_wake");
    WDT_EN <= 1'b1;
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0002);
    sleep_cmd();
    chk("sleep", {CPU_CLK_EN, PERIPH_CLK_EN, osc_en}, 5'b00011);
    rd(`OSC_CTRL_OFFS, 32'h0000_0002, "sleep_flag");
    WDT_TIMEOUT <= 1'b1;
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("withheld", CPU_CLK_EN, 1'b0);
    waitv(1'b1, 2'h1, n);
    chk("wdt_wake", CLK_SEL, 2'h2);
    rd(`OSC_CTRL_OFFS, 32'h0000_000A, "wake_flag");
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0003);
    waitv(1'b0, 2'h3, n);
    waitv(1'b1, 2'h1, n);
    chk("internal_run", {osc_en[2], osc_en[0]}, 2'b01);
    rd(`OSC_CTRL_OFFS, 32'h0000_0003, "osc_rc");
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0002);
    repeat (3) @(posedge CLK);
    chk("hold_rc", {CLK_SEL, CPU_CLK_EN}, 3'b111);
    waitv(1'b0, 2'h2, n);
    waitv(1'b1, 2'h1, n);
    rd(`OSC_CTRL_OFFS, 32'h0000_000A, "rc_back");
    // Timer1 restarted just before selection: clocks must wait for it
    apb(`T1_CTRL_OFFS, 1'b1, 32'h0000_0000);
    apb(`T1_CTRL_OFFS, 1'b1, 32'h0000_0008);
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge CLK);
    chk("sec_hold_off", {CPU_CLK_EN, PERIPH_CLK_EN, CLK_SEL}, 4'b0010);
    waitv(1'b1, 2'h1, n);
    chk("sec_started", CLK_SEL, 2'h1);
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0002);
    waitv(1'b0, 2'h2, n);
    waitv(1'b1, 2'h1, n);
    FSCM_EN <= 1'b1;
    sleep_cmd();
    repeat (2) @(posedge CLK);
    WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    WAKE_IRQ <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("fast_wake", {CPU_CLK_EN, PERIPH_CLK_EN, CLK_SEL}, 4'b0111);
    waitv(1'b1, 2'h1, n);
    chk("fast_wake_pri", CLK_SEL, 2'h2);
    rd(`OSC_CTRL_OFFS, 32'h0000_000A, "fast_flag");
    apb(`OSC_CTRL_OFFS, 1'b1, 32'h0000_0003);
    waitv(1'b0, 2'h3, n);
    // second reset in mid-run, now with two-speed start-up
    TWO_SPEED_EN <= 1'b1;
    RST_N <= 1'b0;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("two_speed", {CLK_SEL, CPU_CLK_EN, PERIPH_CLK_EN}, 4'b1111);
    waitv(1'b0, 2'h2, n);
    waitv(1'b1, 2'h1, n);
    rd(`OSC_CTRL_OFFS, 32'h0000_000A, "two_speed_pri");
    close_out();
  end
endmodule
